// ===== dv/ssir_asserts.sv
// Port-level checker for the sync monitor and interrupt routing block
`timescale 1ns/1ps
module ssir_asserts #(
  parameter int unsigned ROT_CYCLES = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ssir_pkg::AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sync_edge_in,
  input wire ssir_pkg::ssir_events_t ev_in,
  input wire logic interrupt_out_a,
  input wire logic interrupt_out_b,
  input wire logic irq,
  input wire logic serial_link_reset,
  input wire logic oscillator_reset
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_r, wr_r, sum_r, sync_q;
  ssir_pkg::ssir_events_t ev_q;
  logic [3:0] calm_r;
  logic [7:0] hi_r;
  wire take = hsel && hready && htrans == ssir_pkg::HTRANS_NONSEQ;
  // Quiet when no event or sync input moved for eight cycles
  wire calm = calm_r >= 4'h8;
  wire moved = ev_q != ev_in || sync_q != sync_edge_in;
  always_ff @(posedge hclk) begin
    ev_q <= ev_in;
    sync_q <= sync_edge_in;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      sum_r <= 1'b0;
      calm_r <= 4'h0;
      hi_r <= 8'h00;
    end else begin
      rd_r <= take && !hwrite;
      wr_r <= take && hwrite;
      sum_r <= take && hwrite && haddr[9:2] == ssir_pkg::IDX_SUMMARY;
      calm_r <= moved ? 4'h0 : calm_r + {3'h0, !calm};
      hi_r <= serial_link_reset ? hi_r + 8'h01 : 8'h00;
    end
  end
  chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp) else $error("hresp not OKAY");
  chk_rdata_idle: assert property (!rd_r |-> hrdata == ssir_pkg::ZERO32)
    else $error("hrdata outside read data phase");
  chk_reset_quiet: assert property (!$past(hresetn) |-> !(irq || interrupt_out_a
    || interrupt_out_b || serial_link_reset || oscillator_reset))
    else $error("outputs active after reset");
  chk_clear_all: assert property (
    sum_r && hwdata[0] && calm |=> !(irq || interrupt_out_a || interrupt_out_b))
    else $error("summary clear left events");
  chk_irq_cause: assert property (
    $rose(irq) |-> $past(wr_r) || !calm) else $error("irq rose without cause");
  chk_pin_cause: assert property (
    $rose(interrupt_out_a || interrupt_out_b) |-> $past(wr_r) || !calm)
    else $error("pin rose without cause");
  chk_osc_pulse: assert property (
    oscillator_reset |=> !oscillator_reset) else $error("oscillator reset too long");
  chk_link_len: assert property (
    hi_r <= ROT_CYCLES) else $error("link reset too long");
endmodule
bind ssir_top ssir_asserts #(.ROT_CYCLES(ROT_CYCLES)) ssir_asserts_inst (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .sync_edge_in, .ev_in, .interrupt_out_a, .interrupt_out_b, .irq, .serial_link_reset,
  .oscillator_reset);

// ===== dv/ssir_sync_src.sv
// Sync reference source with programmable edge spacing
`timescale 1ns/1ps
module ssir_sync_src (
  input wire logic hclk,
  output logic sync_edge
);
  initial sync_edge = 1'b0;
  // Rising edge now, next rising edge gap cycles later
  task automatic pulse(input int gap);
    sync_edge <= 1'b1;
    repeat (4) @(posedge hclk);
    sync_edge <= 1'b0;
    repeat (gap - 4) @(posedge hclk);
  endtask
endmodule

// ===== dv/tb.sv
// Testbench for the sync monitor and interrupt routing block
`timescale 1ns/1ps
module tb;
  localparam int unsigned RC = 4;
  localparam int RBIT [5] = '{0, 1, 4, 5, 0};
  localparam logic [7:0] RIX [7] = '{8'h2b, 8'h2c, 8'h36, 8'h39, 8'h3a, 8'h3b, 8'h3c};
  localparam logic [7:0] RST [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'hb0, 8'h00};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rv;
  logic hready, hreadyout, hresp, sync_edge_in, interrupt_out_a, interrupt_out_b, irq;
  logic serial_link_reset, oscillator_reset;
  ssir_pkg::ssir_events_t ev_in = '0;
  int mismatches = 0, n_tests = 0, cyc = 0, lnk = 0, osc = 0;
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  ssir_top #(.ROT_CYCLES(RC)) ssir_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .sync_edge_in, .ev_in,
    .interrupt_out_a, .interrupt_out_b, .irq, .serial_link_reset, .oscillator_reset);
  ssir_sync_src ssir_sync_src_inst (.hclk, .sync_edge(sync_edge_in));
  task print_verdict;
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (serial_link_reset === 1'b1) lnk <= lnk + 1;
    if (oscillator_reset === 1'b1) osc <= osc + 1;
    if (cyc == 8000) begin
      mismatches++;
      print_verdict();
    end
  end
  task ck(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= ssir_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {2'h0, i, 2'h0};
    hsize <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hsize <= 3'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rv = hrdata;
  endtask
  task t_reset;
    for (int k = 0; k < 7; k++) begin
      xfer(1'b0, RIX[k], 32'h0000_0000);
      ck(rv, {24'h00_0000, RST[k]});
    end
    xfer(1'b1, ssir_pkg::IDX_JIT_TOL, 32'h0000_00ff);
    xfer(1'b0, ssir_pkg::IDX_JIT_TOL, 32'h0000_0000);
    ck(rv, 32'h0000_007f);
  endtask
  task t_route;
    logic [7:0] ri, rb, sb;
    for (int k = 0; k < 5; k++) begin
      ri = (k == 4) ? ssir_pkg::IDX_PIN_ROUTE_ONE : ssir_pkg::IDX_PIN_ROUTE_TWO;
      rb = 8'h01 << RBIT[k];
      sb = 8'h01 << (4 - k);
      xfer(1'b1, ri, 32'h0000_0000);
      ev_in <= 5'h01 << k;
      repeat (10) @(posedge hclk);
      ck({interrupt_out_a, interrupt_out_b}, 2'h2);
      xfer(1'b0, ssir_pkg::IDX_SUMMARY, 32'h0000_0000);
      ck(rv, 32'h0000_0001);
      xfer(1'b0, ssir_pkg::IDX_EVT_STATUS, 32'h0000_0000);
      ck(rv[7:0], sb);
      xfer(1'b1, ri, {24'h00_0000, rb});
      @(posedge hclk);
      ck({interrupt_out_a, interrupt_out_b}, 2'h1);
      xfer(1'b1, ssir_pkg::IDX_EVT_ENABLE, 32'h0000_0000);
      @(posedge hclk);
      ck({interrupt_out_a, interrupt_out_b}, 2'h0);
      xfer(1'b1, ssir_pkg::IDX_EVT_ENABLE, 32'h0000_003f);
      xfer(1'b1, ssir_pkg::IDX_EVT_MASK, {24'h00_0000, sb});
      @(posedge hclk);
      ck(irq, 1'b1);
      xfer(1'b1, ssir_pkg::IDX_EVT_MASK, 32'h0000_0000);
      xfer(1'b1, ssir_pkg::IDX_SUMMARY, 32'h0000_0001);
      @(posedge hclk);
      ck({interrupt_out_a, interrupt_out_b, irq}, 3'h0);
      ev_in <= '0;
    end
  endtask
  task t_jit;
    xfer(1'b1, ssir_pkg::IDX_PERIOD, 32'h0000_0028);
    xfer(1'b1, ssir_pkg::IDX_JIT_TOL, 32'h0000_0002);
    ssir_sync_src_inst.pulse(40);
    ssir_sync_src_inst.pulse(40);
    ssir_sync_src_inst.pulse(42);
    fork
      ssir_sync_src_inst.pulse(43);
      begin
        repeat (10) @(posedge hclk);
        xfer(1'b0, ssir_pkg::IDX_EVT_STATUS, 32'h0000_0000);
        ck(rv[5], 1'b0);
      end
    join
    ssir_sync_src_inst.pulse(40);
    xfer(1'b0, ssir_pkg::IDX_EVT_STATUS, 32'h0000_0000);
    ck(rv[5], 1'b1);
    ck(interrupt_out_a, 1'b1);
    xfer(1'b1, ssir_pkg::IDX_SUMMARY, 32'h0000_0001);
  endtask
  task t_shot;
    xfer(1'b1, ssir_pkg::IDX_SKIP_COUNT, 32'h0000_0002);
    xfer(1'b1, ssir_pkg::IDX_ROT_CTRL, 32'h0000_00f1);
    xfer(1'b1, ssir_pkg::IDX_MODE, 32'h0000_0002);
    ssir_sync_src_inst.pulse(40);
    ssir_sync_src_inst.pulse(40);
    ck(lnk, 0);
    fork
      ssir_sync_src_inst.pulse(40);
      begin
        for (int i = 0; i < 20 && serial_link_reset !== 1'b1; i++) @(posedge hclk);
        xfer(1'b0, ssir_pkg::IDX_MODE, 32'h0000_0000);
        ck(rv[4], 1'b0);
      end
    join
    ck(lnk, RC);
    ck(osc, 1);
    xfer(1'b0, ssir_pkg::IDX_MODE, 32'h0000_0000);
    ck(rv, 32'h0000_0010);
    ssir_sync_src_inst.pulse(40);
    ck(lnk, RC);
  endtask
  // Rotation with no action bits: no link or oscillator reset
  task t_noact;
    xfer(1'b1, ssir_pkg::IDX_SKIP_COUNT, 32'h0000_0000);
    xfer(1'b1, ssir_pkg::IDX_ROT_CTRL, 32'h0000_00e0);
    xfer(1'b1, ssir_pkg::IDX_MODE, 32'h0000_0002);
    ssir_sync_src_inst.pulse(40);
    xfer(1'b0, ssir_pkg::IDX_MODE, 32'h0000_0000);
    ck(rv, 32'h0000_0010);
    ck(lnk, RC);
    ck(osc, 1);
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_route();
    t_jit();
    t_shot();
    t_noact();
    print_verdict();
  end
endmodule

// ===== hw/ssir_pkg.sv
// Package for the sync edge monitor and interrupt routing block
package ssir_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned AW = 12;
  // Byte addresses are four times the register index
  localparam logic [7:0] IDX_PIN_ROUTE_ONE = 8'h2a;
  localparam logic [7:0] IDX_PIN_ROUTE_TWO = 8'h2b;
  localparam logic [7:0] IDX_SUMMARY = 8'h2c;
  localparam logic [7:0] IDX_SKIP_COUNT = 8'h36;
  localparam logic [7:0] IDX_JIT_TOL = 8'h39;
  localparam logic [7:0] IDX_MODE = 8'h3a;
  localparam logic [7:0] IDX_ROT_CTRL = 8'h3b;
  localparam logic [7:0] IDX_EVT_STATUS = 8'h40;
  localparam logic [7:0] IDX_EVT_MASK = 8'h41;
  localparam logic [7:0] IDX_EVT_ENABLE = 8'h42;
  localparam logic [7:0] IDX_PERIOD = 8'h43;
  // Field positions
  localparam int unsigned B_PA_SEL = 0;
  localparam int unsigned B_DLL_LOST = 5;
  localparam int unsigned B_DLL_LOCK = 4;
  localparam int unsigned B_PLL_LOST = 1;
  localparam int unsigned B_PLL_LOCK = 0;
  localparam int unsigned B_ONESHOT = 1;
  localparam int unsigned B_ROT_DONE = 4;
  localparam int unsigned B_LOGIC_ON = 7;
  localparam int unsigned B_NCO_RST = 4;
  localparam int unsigned B_LINK_RST = 0;
  // Event vector: pa, dll lost, dll lock, pll lost, pll lock, jitter
  localparam int unsigned NEV = 6;
  localparam int unsigned E_PA = 0;
  localparam int unsigned E_DLL_LOST = 1;
  localparam int unsigned E_DLL_LOCK = 2;
  localparam int unsigned E_PLL_LOST = 3;
  localparam int unsigned E_PLL_LOCK = 4;
  localparam int unsigned E_JIT = 5;
  // Reset values
  localparam logic [7:0] RST_ROT_CTRL = 8'hb0;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [NEV-1:0] RST_ENABLE = 6'h3f;
  localparam logic [15:0] RST_PERIOD = 16'h0040;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  typedef enum logic [1:0] {
    SSIR_IDLE = 2'b00,
    SSIR_SKIP = 2'b01,
    SSIR_ROT = 2'b10
  } ssir_state_t;
  typedef struct packed {
    logic pa_error;
    logic dll_lost;
    logic dll_lock;
    logic pll_lost;
    logic pll_lock;
  } ssir_events_t;
endpackage

// ===== hw/ssir_top.sv
// Sync edge monitor, rotation control and interrupt routing
// Summary of operation
// - PA error routed to pin a or b
// - DLL events routed by bits 5 and 4
// - PLL events routed by bits 1 and 0
// - Summary bit is OR of latched events
// - Writing one to summary clears all events
// - Ignore programmed count of sync edges first
// - Hold seven-bit jitter tolerance in clocks
// - Edge outside tolerance raises jitter event
// - Monitor mode only watches and flags jitter
// - One-shot rotates once, then back to monitor
// - Read-only rotation done flag, resets high
// - Rotation with bit 0 resets serial links
// - Oscillator reset after rotation when enabled
`timescale 1ns/1ps
module ssir_top #(
  parameter int unsigned ROT_CYCLES = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ssir_pkg::AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sync_edge_in,
  input wire ssir_pkg::ssir_events_t ev_in,
  output logic interrupt_out_a,
  output logic interrupt_out_b,
  output logic irq,
  output logic serial_link_reset,
  output logic oscillator_reset
);
  localparam int unsigned NEV = ssir_pkg::NEV;

  // Bus address phase capture
  logic wr_pend_r, rd_pend_r;
  logic [7:0] widx_r;
  wire addr_ok = hsel && hready && (htrans == ssir_pkg::HTRANS_NONSEQ);
  wire [7:0] aidx = haddr[9:2];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      widx_r <= ssir_pkg::RST_ZERO;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      rd_pend_r <= addr_ok && !hwrite;
      if (addr_ok) begin
        widx_r <= aidx;
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  function automatic logic wr_to(input logic pend, input logic [7:0] idx,
                                 input logic [7:0] want);
    return pend && (idx == want);
  endfunction

  // Registers
  logic [7:0] route_one_r, route_two_r, skip_r, tol_r, mode_r, rot_ctrl_r;
  logic [NEV-1:0] status_r, mask_r, enable_r;
  logic [15:0] period_r;
  wire [7:0] wb = hwdata[7:0];
  wire w_one = wr_to(wr_pend_r, widx_r, ssir_pkg::IDX_PIN_ROUTE_ONE);
  wire w_two = wr_to(wr_pend_r, widx_r, ssir_pkg::IDX_PIN_ROUTE_TWO);
  wire w_sum = wr_to(wr_pend_r, widx_r, ssir_pkg::IDX_SUMMARY);
  wire w_skip = wr_to(wr_pend_r, widx_r, ssir_pkg::IDX_SKIP_COUNT);
  wire w_tol = wr_to(wr_pend_r, widx_r, ssir_pkg::IDX_JIT_TOL);
  wire w_mode = wr_to(wr_pend_r, widx_r, ssir_pkg::IDX_MODE);
  wire w_rot = wr_to(wr_pend_r, widx_r, ssir_pkg::IDX_ROT_CTRL);
  wire w_stat = wr_to(wr_pend_r, widx_r, ssir_pkg::IDX_EVT_STATUS);
  wire w_mask = wr_to(wr_pend_r, widx_r, ssir_pkg::IDX_EVT_MASK);
  wire w_en = wr_to(wr_pend_r, widx_r, ssir_pkg::IDX_EVT_ENABLE);
  wire w_per = wr_to(wr_pend_r, widx_r, ssir_pkg::IDX_PERIOD);

  // Sync edge input synchroniser
  logic [2:0] sync_r;
  logic edge_lvl_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_r <= 3'h0;
      edge_lvl_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], sync_edge_in};
      if (sync_r[2] == sync_r[1]) begin
        edge_lvl_r <= sync_r[2];
      end
    end
  end
  wire sync_lvl_agree = (sync_r[2] == sync_r[1]);
  wire sync_rise = sync_lvl_agree && sync_r[2] && !edge_lvl_r;

  // Event input synchroniser
  logic [4:0] ev_s1_r, ev_s2_r, ev_s3_r, ev_lvl_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_s1_r <= 5'h00;
      ev_s2_r <= 5'h00;
      ev_s3_r <= 5'h00;
      ev_lvl_r <= 5'h00;
    end else begin
      ev_s1_r <= ev_in;
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
      ev_lvl_r <= (ev_s2_r & ev_s3_r) | (ev_lvl_r & (ev_s2_r | ev_s3_r));
    end
  end
  ssir_pkg::ssir_events_t ev_q;
  assign ev_q = ev_lvl_r;

  wire [6:0] tol = tol_r[6:0];
  // Phase counter against expected edge period
  logic [15:0] phase_r;
  wire [15:0] dev_late = phase_r - period_r;
  wire [15:0] dev_early = period_r - phase_r;
  wire late = (phase_r >= period_r);
  wire [15:0] dev = late ? dev_late : dev_early;
  wire jit_hit = sync_rise && (dev > {9'h000, tol});
  logic seen_edge_r;

  // Rotation state machine
  ssir_pkg::ssir_state_t st_r, st_nxt;
  logic [7:0] skip_cnt_r;
  logic [7:0] rot_cnt_r;
  logic done_r;
  wire logic_on = rot_ctrl_r[ssir_pkg::B_LOGIC_ON];
  wire oneshot = mode_r[ssir_pkg::B_ONESHOT];
  wire skip_done = (skip_cnt_r >= skip_r);
  wire rot_last = (rot_cnt_r == 8'(ROT_CYCLES - 1));
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ssir_pkg::SSIR_IDLE: begin
        if (logic_on && oneshot && sync_rise) begin
          st_nxt = skip_done ? ssir_pkg::SSIR_ROT : ssir_pkg::SSIR_SKIP;
        end
      end
      ssir_pkg::SSIR_SKIP: begin
        if (sync_rise && (skip_cnt_r + 8'h01 >= skip_r)) begin
          st_nxt = ssir_pkg::SSIR_ROT;
        end
      end
      ssir_pkg::SSIR_ROT: begin
        if (rot_last) begin
          st_nxt = ssir_pkg::SSIR_IDLE;
        end
      end
      default: st_nxt = ssir_pkg::SSIR_IDLE;
    endcase
  end
  wire rot_start = (st_r != ssir_pkg::SSIR_ROT) && (st_nxt == ssir_pkg::SSIR_ROT);
  wire rot_end = (st_r == ssir_pkg::SSIR_ROT) && rot_last;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ssir_pkg::SSIR_IDLE;
      skip_cnt_r <= ssir_pkg::RST_ZERO;
      rot_cnt_r <= ssir_pkg::RST_ZERO;
      done_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      if (st_r == ssir_pkg::SSIR_IDLE) begin
        skip_cnt_r <= ssir_pkg::RST_ZERO;
      end else if (sync_rise) begin
        skip_cnt_r <= skip_cnt_r + 8'h01;
      end
      rot_cnt_r <= (st_r == ssir_pkg::SSIR_ROT) ? rot_cnt_r + 8'h01 : ssir_pkg::RST_ZERO;
      if (rot_start) begin
        done_r <= 1'b0;
      end else if (rot_end) begin
        done_r <= 1'b1;
      end
    end
  end

  wire link_rst_nxt = (st_r == ssir_pkg::SSIR_ROT) && rot_ctrl_r[ssir_pkg::B_LINK_RST];
  wire osc_rst_nxt = rot_end && rot_ctrl_r[ssir_pkg::B_NCO_RST];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_link_reset <= 1'b0;
      oscillator_reset <= 1'b0;
      phase_r <= 16'h0000;
      seen_edge_r <= 1'b0;
    end else begin
      serial_link_reset <= link_rst_nxt;
      oscillator_reset <= osc_rst_nxt;
      // Saturate so a long quiet spell never wraps into a near-period gap
      phase_r <= (sync_rise || rot_end) ? 16'h0001 : phase_r + {15'h0000, ~&phase_r};
      if (sync_rise) begin
        seen_edge_r <= 1'b1;
      end
    end
  end

  // Sticky events; set wins over clear
  // Jitter flagged in monitor mode
  wire jit_ev = jit_hit && seen_edge_r && (st_r == ssir_pkg::SSIR_IDLE) && !oneshot;
  wire [NEV-1:0] ev_vec = {jit_ev, ev_q.pll_lock, ev_q.pll_lost,
                           ev_q.dll_lock, ev_q.dll_lost, ev_q.pa_error};
  logic [NEV-1:0] ev_d_r;
  wire [NEV-1:0] ev_set = ev_vec & ~ev_d_r & enable_r;
  wire clr_all = w_sum && wb[0];
  wire [NEV-1:0] clr_vec = (w_stat ? hwdata[NEV-1:0] : {NEV{1'b0}}) | {NEV{clr_all}};
  wire [NEV-1:0] status_nxt = ev_set | (status_r & ~clr_vec);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= {NEV{1'b0}};
      ev_d_r <= {NEV{1'b0}};
    end else begin
      status_r <= status_nxt;
      ev_d_r <= ev_vec;
    end
  end

  // Register writes, one short block per register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      route_one_r <= ssir_pkg::RST_ZERO;
    end else if (w_one) begin
      route_one_r <= {7'h00, wb[ssir_pkg::B_PA_SEL]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      route_two_r <= ssir_pkg::RST_ZERO;
    end else if (w_two) begin
      route_two_r <= wb & 8'h33;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      skip_r <= ssir_pkg::RST_ZERO;
    end else if (w_skip) begin
      skip_r <= wb;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tol_r <= ssir_pkg::RST_ZERO;
    end else if (w_tol) begin
      tol_r <= {1'b0, wb[6:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= ssir_pkg::RST_MODE;
    end else if (rot_end) begin
      mode_r[ssir_pkg::B_ONESHOT] <= 1'b0;
    end else if (w_mode) begin
      mode_r <= wb & 8'h03;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rot_ctrl_r <= ssir_pkg::RST_ROT_CTRL;
    end else if (w_rot) begin
      rot_ctrl_r <= wb & 8'hf3;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_r <= {NEV{1'b0}};
    end else if (w_mask) begin
      mask_r <= hwdata[NEV-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_r <= ssir_pkg::RST_ENABLE;
    end else if (w_en) begin
      enable_r <= hwdata[NEV-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_r <= ssir_pkg::RST_PERIOD;
    end else if (w_per) begin
      period_r <= hwdata[15:0];
    end
  end

  wire [NEV-1:0] sel_b;
  assign sel_b[ssir_pkg::E_PA] = route_one_r[ssir_pkg::B_PA_SEL];
  assign sel_b[ssir_pkg::E_DLL_LOST] = route_two_r[ssir_pkg::B_DLL_LOST];
  assign sel_b[ssir_pkg::E_DLL_LOCK] = route_two_r[ssir_pkg::B_DLL_LOCK];
  assign sel_b[ssir_pkg::E_PLL_LOST] = route_two_r[ssir_pkg::B_PLL_LOST];
  assign sel_b[ssir_pkg::E_PLL_LOCK] = route_two_r[ssir_pkg::B_PLL_LOCK];
  assign sel_b[ssir_pkg::E_JIT] = 1'b0;
  wire [NEV-1:0] live = status_r & enable_r;
  assign interrupt_out_a = |(live & ~sel_b);
  assign interrupt_out_b = |(live & sel_b);
  assign irq = |(status_r & mask_r);

  wire summary = |status_r;
  logic [31:0] rd_mux;
  always_comb begin
    case (widx_r)
      ssir_pkg::IDX_PIN_ROUTE_ONE: rd_mux = {24'h00_0000, route_one_r};
      ssir_pkg::IDX_PIN_ROUTE_TWO: rd_mux = {24'h00_0000, route_two_r};
      ssir_pkg::IDX_SUMMARY: rd_mux = {31'h0000_0000, summary};
      ssir_pkg::IDX_SKIP_COUNT: rd_mux = {24'h00_0000, skip_r};
      ssir_pkg::IDX_JIT_TOL: rd_mux = {24'h00_0000, tol_r};
      // Done flag read-only at bit 4
      ssir_pkg::IDX_MODE: rd_mux = {24'h00_0000, mode_r | {3'h0, done_r, 4'h0}};
      ssir_pkg::IDX_ROT_CTRL: rd_mux = {24'h00_0000, rot_ctrl_r};
      ssir_pkg::IDX_EVT_STATUS: rd_mux = {26'h000_0000, status_r};
      ssir_pkg::IDX_EVT_MASK: rd_mux = {26'h000_0000, mask_r};
      ssir_pkg::IDX_EVT_ENABLE: rd_mux = {26'h000_0000, enable_r};
      ssir_pkg::IDX_PERIOD: rd_mux = {16'h0000, period_r};
      default: rd_mux = ssir_pkg::ZERO32;
    endcase
  end
  assign hrdata = rd_pend_r ? rd_mux : ssir_pkg::ZERO32;
endmodule
